/* File: design/isc_pkg.sv */
// package: register map, field layouts, modes and state record of the i2c port block
package isc_pkg;

	// ==========================================================
	// register map (plain port, word index)
	localparam int unsigned ADDR_W = 3;
	localparam logic [ADDR_W-1:0] REG_CTRL1 = 3'h0;
	localparam logic [ADDR_W-1:0] REG_CTRL2 = 3'h1;
	localparam logic [ADDR_W-1:0] REG_CTRL3 = 3'h2;
	localparam logic [ADDR_W-1:0] REG_ADDR_BAUD = 3'h3;
	localparam logic [ADDR_W-1:0] REG_MASK = 3'h4;
	localparam logic [ADDR_W-1:0] REG_BUF = 3'h5;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h6;

	// ==========================================================
	// port mode field codes
	localparam logic [3:0] MODE_SLAVE7 = 4'h6;
	localparam logic [3:0] MODE_SLAVE10 = 4'h7;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_FW_MASTER = 4'hb;

	// ==========================================================
	// constants
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] MASK_A7_1 = 8'hfe;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_CLOCK = 4'h9;

	// ==========================================================
	// register layouts, msb first
	typedef struct packed {
		logic [1:0] rsvd;
		logic port_enable_bit;
		logic clock_release_bit;
		logic [3:0] port_mode_field;
	} isc_ctrl1_s;

	typedef struct packed {
		logic general_call_enable;
		logic ack_status;
		logic ack_value_bit;
		logic ack_enable;
		logic receive_enable;
		logic stop_enable_bit;
		logic restart_enable;
		logic start_enable_bit;
	} isc_ctrl2_s;

	typedef struct packed {
		logic [6:0] rsvd;
		logic address_hold_enable;
	} isc_ctrl3_s;

	typedef struct packed {
		logic write_collision_flag;
		logic read_write;
		logic buf_full;
		logic stop_seen;
		logic start_seen;
		logic update_address_flag;
		logic bus_collision_flag;
		logic port_interrupt_flag;
	} isc_status_s;

	typedef enum logic [2:0] {SP_IDLE, SP_ADDR, SP_ADDR_LO, SP_DATA, SP_IGNORE} isc_sphase_e;
	typedef enum logic [2:0] {
		M_IDLE, M_START_WAIT, M_START_HOLD, M_BIT_LOW, M_BIT_HIGH,
		M_STOP_LOW, M_STOP_HIGH, M_STOP_SDA
	} isc_mstate_e;

	// ==========================================================
	// whole state of the block
	typedef struct packed {
		logic scl_m;
		logic sda_m;
		logic scl_s;
		logic sda_s;
		logic scl_p;
		logic sda_p;
		isc_ctrl1_s ctrl1;
		isc_ctrl2_s ctrl2;
		isc_ctrl3_s ctrl3;
		logic [7:0] addr_baud;
		logic [7:0] mask;
		logic [7:0] shift_buffer;
		isc_status_s stat;
		logic [7:0] rdata;
		isc_sphase_e s_phase;
		logic [3:0] s_bit;
		logic [7:0] shift_register;
		logic s_ack;
		logic s_hold;
		logic s_stretch;
		isc_mstate_e m_state;
		logic [7:0] baud_counter;
		logic [3:0] m_bit;
		logic [7:0] m_sh;
		logic m_rx;
		logic m_scl_low;
		logic m_sda_low;
		logic scl_oe_n;
		logic sda_oe_n;
	} isc_state_s;

	localparam isc_state_s ST_RST = '{
		scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1, scl_p: 1'b1, sda_p: 1'b1,
		mask: MASK_RST, s_phase: SP_IDLE, m_state: M_IDLE,
		scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0
	};

endpackage : isc_pkg

/* File: design/isc_top.sv */
// i2c port block: slave address match, clock hold, master start/byte/stop engine
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps

// Contract
// - clock hold waits for scl low first
// - general call enable acks address zero
// - all-zero write address raises interrupt flag
// - general call never sets update-address flag
// - address hold also stretches general call
// - zero mask bit makes address bit don't-care
// - reset loads address mask all ones
// - mask covers A7:1, ten-bit low byte only
// - mode plus enable select master; pull only
// - start/stop seen cleared; bus free rule
// - firmware master: only start/stop detection
// - master events set port interrupt flag
// - buffer write before start done collides
// - master start/stop flagged on self-clear only
// - master transmits bytes, receives acknowledge
// - master receives bytes, sends acknowledge
// - baud counter reloads until scl high
// - busy buffer write is dropped, flags collision
// - second control low bits locked during start
// - start: reload, sda low, then scl low
// - start end clears enable, suspends counter
// - start collision sets flag and aborts
module isc_top
	import isc_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SCL_OUT,
	output logic SCL_OE_N,
	output logic SDA_OUT,
	output logic SDA_OE_N
);

	isc_state_s st_r;
	isc_state_s st_nxt;

	// ==========================================================
	// next state
	always_comb begin
		logic start_det;
		logic stop_det;
		logic scl_rise;
		logic scl_fall;
		logic on;
		logic master;
		logic fw;
		logic slave;
		logic ten;
		logic m_busy;
		logic bus_free;
		logic gc;
		logic hit;
		logic slave_sda;
		isc_ctrl2_s w2;
		isc_status_s ws;
		start_det = st_r.scl_s & st_r.scl_p & st_r.sda_p & ~st_r.sda_s;
		stop_det = st_r.scl_s & st_r.scl_p & ~st_r.sda_p & st_r.sda_s;
		scl_rise = st_r.scl_s & ~st_r.scl_p;
		scl_fall = ~st_r.scl_s & st_r.scl_p;
		on = st_r.ctrl1.port_enable_bit;
		master = on && (st_r.ctrl1.port_mode_field == MODE_MASTER);
		fw = on && (st_r.ctrl1.port_mode_field == MODE_FW_MASTER);
		ten = st_r.ctrl1.port_mode_field == MODE_SLAVE10;
		slave = on && (ten || st_r.ctrl1.port_mode_field == MODE_SLAVE7);
		m_busy = (st_r.m_state != M_IDLE) || st_r.ctrl2.start_enable_bit
			|| st_r.ctrl2.stop_enable_bit || st_r.ctrl2.receive_enable;
		bus_free = st_r.stat.stop_seen || !st_r.stat.start_seen;
		gc = st_r.ctrl2.general_call_enable && (st_r.shift_register == 8'h00);
		hit = 1'b0;
		slave_sda = 1'b0;
		w2 = isc_ctrl2_s'(WDATA);
		ws = isc_status_s'(WDATA);
		st_nxt = st_r;
		// pin synchronisers, then one more stage for edge finding
		st_nxt.scl_m = SCL_IN;
		st_nxt.sda_m = SDA_IN;
		st_nxt.scl_s = st_r.scl_m;
		st_nxt.sda_s = st_r.sda_m;
		st_nxt.scl_p = st_r.scl_s;
		st_nxt.sda_p = st_r.sda_s;
		st_nxt.rdata = 8'h00;

		// register reads; data stand only in the following cycle
		if (RD) begin
			if (ADDR == REG_CTRL1) begin
				st_nxt.rdata = st_r.ctrl1;
			end else if (ADDR == REG_CTRL2) begin
				st_nxt.rdata = st_r.ctrl2;
			end else if (ADDR == REG_CTRL3) begin
				st_nxt.rdata = st_r.ctrl3;
			end else if (ADDR == REG_ADDR_BAUD) begin
				st_nxt.rdata = st_r.addr_baud;
			end else if (ADDR == REG_MASK) begin
				st_nxt.rdata = st_r.mask;
			end else if (ADDR == REG_BUF) begin
				st_nxt.rdata = st_r.shift_buffer;
				st_nxt.stat.buf_full = 1'b0;
			end else if (ADDR == REG_STATUS) begin
				st_nxt.rdata = st_r.stat;
			end
		end

		// register writes; hardware events below override them
		if (WR) begin
			if (ADDR == REG_CTRL1) begin
				st_nxt.ctrl1 = isc_ctrl1_s'(WDATA);
				st_nxt.ctrl1.rsvd = 2'b00;
			end else if (ADDR == REG_CTRL2) begin
				st_nxt.ctrl2.general_call_enable = w2.general_call_enable;
				st_nxt.ctrl2.ack_value_bit = w2.ack_value_bit;
				// no queueing: the low bits are frozen while a start runs
				if (!st_r.ctrl2.start_enable_bit && master && !m_busy) begin
					st_nxt.ctrl2.start_enable_bit = w2.start_enable_bit;
					st_nxt.ctrl2.stop_enable_bit = w2.stop_enable_bit;
					st_nxt.ctrl2.receive_enable = w2.receive_enable;
				end
			end else if (ADDR == REG_CTRL3) begin
				st_nxt.ctrl3.address_hold_enable = WDATA[0];
			end else if (ADDR == REG_ADDR_BAUD) begin
				st_nxt.addr_baud = WDATA;
				st_nxt.stat.update_address_flag = 1'b0;
			end else if (ADDR == REG_MASK) begin
				st_nxt.mask = WDATA;
			end else if (ADDR == REG_BUF) begin
				if (master && m_busy) begin
					st_nxt.stat.write_collision_flag = 1'b1;
				end else begin
					st_nxt.shift_buffer = WDATA;
					if (master) begin
						// a write in master idle launches a transmit byte
						st_nxt.stat.buf_full = 1'b1;
						st_nxt.m_sh = WDATA;
						st_nxt.m_rx = 1'b0;
						st_nxt.m_bit = 4'h0;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_scl_low = 1'b1;
						st_nxt.m_state = M_BIT_LOW;
					end
				end
			end else if (ADDR == REG_STATUS) begin
				st_nxt.stat.port_interrupt_flag = st_r.stat.port_interrupt_flag
					& ~ws.port_interrupt_flag;
				st_nxt.stat.bus_collision_flag = st_r.stat.bus_collision_flag
					& ~ws.bus_collision_flag;
				st_nxt.stat.write_collision_flag = st_r.stat.write_collision_flag
					& ~ws.write_collision_flag;
			end
		end

		// bus condition detection; only firmware master raises the flag on it
		if (start_det) begin
			st_nxt.stat.start_seen = 1'b1;
			st_nxt.stat.stop_seen = 1'b0;
		end else if (stop_det) begin
			st_nxt.stat.stop_seen = 1'b1;
			st_nxt.stat.start_seen = 1'b0;
		end
		if (fw && (start_det || stop_det)) begin
			st_nxt.stat.port_interrupt_flag = 1'b1;
		end

		// slave receive and address compare
		if (!slave) begin
			st_nxt.s_phase = SP_IDLE;
			st_nxt.s_ack = 1'b0;
		end else if (start_det) begin
			st_nxt.s_phase = SP_ADDR;
			st_nxt.s_bit = 4'h0;
			st_nxt.s_ack = 1'b0;
		end else if (stop_det) begin
			st_nxt.s_phase = SP_IDLE;
			st_nxt.s_ack = 1'b0;
		end else if (st_r.s_phase != SP_IDLE) begin
			if (scl_rise && st_r.s_bit < BITS_PER_BYTE) begin
				st_nxt.shift_register = {st_r.shift_register[6:0], st_r.sda_s};
				st_nxt.s_bit = st_r.s_bit + 4'h1;
			end else if (scl_rise && st_r.s_bit == BITS_PER_BYTE) begin
				st_nxt.s_bit = ACK_CLOCK;
			end else if (scl_fall && st_r.s_bit == ACK_CLOCK) begin
				st_nxt.s_ack = 1'b0;
				st_nxt.s_bit = 4'h0;
			end else if (scl_fall && st_r.s_bit == BITS_PER_BYTE) begin
				// byte complete at the 8th falling edge
				case (st_r.s_phase)
					SP_ADDR: begin
						if (gc) begin
							hit = 1'b1;
							st_nxt.s_phase = SP_DATA;
						end else if (ten) begin
							// high byte is compared exactly, mask not applied
							if (st_r.shift_register[7:3] == TEN_BIT_PREFIX
								&& st_r.shift_register[2:1] == st_r.addr_baud[2:1]
								&& !st_r.shift_register[0]) begin
								hit = 1'b1;
								st_nxt.stat.update_address_flag = 1'b1;
								st_nxt.s_phase = SP_ADDR_LO;
							end else begin
								st_nxt.s_phase = SP_IGNORE;
							end
						end else if (((st_r.shift_register ^ st_r.addr_baud) & st_r.mask
							& MASK_A7_1) == 8'h00) begin
							hit = 1'b1;
							st_nxt.s_phase = SP_DATA;
						end else begin
							st_nxt.s_phase = SP_IGNORE;
						end
						if (hit) begin
							st_nxt.stat.read_write = st_r.shift_register[0];
						end
					end
					SP_ADDR_LO: begin
						// flag raised even on a miss so software can restore the address
						st_nxt.stat.update_address_flag = 1'b1;
						st_nxt.stat.port_interrupt_flag = 1'b1;
						if (((st_r.shift_register ^ st_r.addr_baud) & st_r.mask) == 8'h00) begin
							hit = 1'b1;
							st_nxt.s_phase = SP_DATA;
						end else begin
							st_nxt.s_phase = SP_IGNORE;
						end
					end
					SP_DATA: begin
						hit = 1'b1;
					end
					default: begin
						hit = 1'b0;
					end
				endcase
				if (hit) begin
					st_nxt.s_ack = 1'b1;
					st_nxt.shift_buffer = st_r.shift_register;
					st_nxt.stat.buf_full = 1'b1;
					st_nxt.stat.port_interrupt_flag = 1'b1;
					st_nxt.s_hold = st_r.ctrl3.address_hold_enable && (st_r.s_phase != SP_DATA);
					if (st_r.ctrl3.address_hold_enable && st_r.s_phase != SP_DATA) begin
						st_nxt.ctrl1.clock_release_bit = 1'b0;
					end
				end
			end
		end
		// hold starts only once scl is seen low, ends when software releases
		st_nxt.s_stretch = slave && !st_r.ctrl1.clock_release_bit
			&& (st_r.s_stretch || !st_r.scl_s);

		// master engine; every wait counts the baud period
		if (!master) begin
			st_nxt.m_state = M_IDLE;
			st_nxt.m_scl_low = 1'b0;
			st_nxt.m_sda_low = 1'b0;
		end else begin
			case (st_r.m_state)
				M_IDLE: begin
					if (st_r.ctrl2.start_enable_bit) begin
						if ((!st_r.scl_s && !st_r.sda_s) || !bus_free) begin
							st_nxt.stat.bus_collision_flag = 1'b1;
							st_nxt.ctrl2.start_enable_bit = 1'b0;
						end else begin
							st_nxt.baud_counter = st_r.addr_baud;
							st_nxt.m_state = M_START_WAIT;
						end
					end else if (st_r.ctrl2.stop_enable_bit) begin
						st_nxt.m_scl_low = 1'b1;
						st_nxt.m_sda_low = 1'b1;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_STOP_LOW;
					end else if (st_r.ctrl2.receive_enable) begin
						st_nxt.m_rx = 1'b1;
						st_nxt.m_bit = 4'h0;
						st_nxt.m_scl_low = 1'b1;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_BIT_LOW;
					end
				end
				M_START_WAIT: begin
					if (!st_r.scl_s || (st_r.baud_counter == 8'h00 && !st_r.sda_s)) begin
						st_nxt.stat.bus_collision_flag = 1'b1;
						st_nxt.ctrl2.start_enable_bit = 1'b0;
						st_nxt.m_state = M_IDLE;
					end else if (st_r.baud_counter == 8'h00) begin
						st_nxt.m_sda_low = 1'b1;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_START_HOLD;
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
				M_START_HOLD: begin
					if (st_r.baud_counter == 8'h00) begin
						st_nxt.m_scl_low = 1'b1;
						st_nxt.ctrl2.start_enable_bit = 1'b0;
						st_nxt.stat.port_interrupt_flag = 1'b1;
						st_nxt.m_state = M_IDLE;
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
				M_BIT_LOW: begin
					// data bits: tx drives, rx floats; ninth bit the other way round
					if (st_r.m_bit == BITS_PER_BYTE) begin
						st_nxt.m_sda_low = st_r.m_rx && !st_r.ctrl2.ack_value_bit;
					end else begin
						st_nxt.m_sda_low = !st_r.m_rx && !st_r.m_sh[7];
					end
					if (st_r.baud_counter == 8'h00) begin
						st_nxt.m_scl_low = 1'b0;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_BIT_HIGH;
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
				M_BIT_HIGH: begin
					if (!st_r.scl_s) begin
						st_nxt.baud_counter = st_r.addr_baud;
					end else if (st_r.baud_counter == 8'h00) begin
						st_nxt.m_scl_low = 1'b1;
						st_nxt.m_bit = st_r.m_bit + 4'h1;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_BIT_LOW;
						if (st_r.m_bit == BITS_PER_BYTE) begin
							if (st_r.m_rx) begin
								st_nxt.shift_buffer = st_r.m_sh;
								st_nxt.stat.buf_full = 1'b1;
								st_nxt.ctrl2.receive_enable = 1'b0;
							end else begin
								st_nxt.ctrl2.ack_status = st_r.sda_s;
								st_nxt.stat.buf_full = 1'b0;
							end
							st_nxt.m_sda_low = 1'b0;
							st_nxt.stat.port_interrupt_flag = 1'b1;
							st_nxt.m_state = M_IDLE;
						end else begin
							st_nxt.m_sh = {st_r.m_sh[6:0], st_r.sda_s};
						end
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
				M_STOP_LOW: begin
					if (st_r.baud_counter == 8'h00) begin
						st_nxt.m_scl_low = 1'b0;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_STOP_HIGH;
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
				M_STOP_HIGH: begin
					if (!st_r.scl_s) begin
						st_nxt.baud_counter = st_r.addr_baud;
					end else if (st_r.baud_counter == 8'h00) begin
						st_nxt.m_sda_low = 1'b0;
						st_nxt.baud_counter = st_r.addr_baud;
						st_nxt.m_state = M_STOP_SDA;
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
				default: begin
					if (st_r.baud_counter == 8'h00) begin
						st_nxt.ctrl2.stop_enable_bit = 1'b0;
						st_nxt.stat.port_interrupt_flag = 1'b1;
						st_nxt.m_state = M_IDLE;
					end else begin
						st_nxt.baud_counter = st_r.baud_counter - 8'h01;
					end
				end
			endcase
		end

		// disabling the port forgets bus conditions and pending commands
		if (!on) begin
			st_nxt.stat.start_seen = 1'b0;
			st_nxt.stat.stop_seen = 1'b0;
			st_nxt.ctrl2.start_enable_bit = 1'b0;
			st_nxt.ctrl2.stop_enable_bit = 1'b0;
			st_nxt.ctrl2.receive_enable = 1'b0;
		end

		// open drain: enable low only while something must pull
		slave_sda = st_nxt.s_ack && !(st_nxt.s_hold && st_nxt.ctrl2.ack_value_bit);
		st_nxt.scl_oe_n = !(st_nxt.s_stretch || st_nxt.m_scl_low);
		st_nxt.sda_oe_n = !(slave_sda || st_nxt.m_sda_low);
	end

	// ==========================================================
	// state register
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA = st_r.rdata;
	assign SCL_OUT = st_r.ctrl1.rsvd[0]; // constant zero flop, pin only ever pulls low
	assign SDA_OUT = st_r.ctrl1.rsvd[1];
	assign SCL_OE_N = st_r.scl_oe_n;
	assign SDA_OE_N = st_r.sda_oe_n;

	// ==========================================================
	// checks
	chk_hold_after_low: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$rose(st_r.s_stretch) |-> !$past(st_r.scl_s))
		else $error("slave pulled scl before it was low");
	chk_mask_reset: assert property (@(posedge REF_CLK)
		$rose(RESET_N) |-> st_r.mask == MASK_RST)
		else $error("mask not all ones after reset");
	chk_gc_flag: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.s_phase == SP_ADDR && st_r.s_bit == BITS_PER_BYTE && st_r.scl_p && !st_r.scl_s
		&& st_r.ctrl2.general_call_enable && st_r.shift_register == 8'h00
		&& st_r.ctrl1.port_enable_bit && !st_r.ctrl1.port_mode_field[3]
		|=> st_r.stat.port_interrupt_flag && st_r.s_ack && !$changed(st_r.stat.update_address_flag))
		else $error("general call not acknowledged");
	chk_write_collision_flag_busy: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WR && ADDR == REG_BUF && st_r.m_state != M_IDLE
		|=> st_r.stat.write_collision_flag && $stable(st_r.shift_buffer))
		else $error("busy buffer write not refused");
	chk_ctrl2_lock: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WR && ADDR == REG_CTRL2 && st_r.ctrl2.start_enable_bit
		|=> $stable(st_r.ctrl2.stop_enable_bit) && $stable(st_r.ctrl2.receive_enable))
		else $error("control written during start");
	chk_start_sda: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.m_state == M_START_WAIT && st_r.baud_counter == 8'h00 && st_r.scl_s && st_r.sda_s
		&& st_r.ctrl1.port_enable_bit
		|=> st_r.m_state == M_START_HOLD ##1 !st_r.sda_oe_n && st_r.scl_oe_n)
		else $error("start did not drive sda alone");
	chk_start_done: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.m_state == M_START_HOLD && st_r.baud_counter == 8'h00 && st_r.ctrl1.port_enable_bit
		|=> !st_r.ctrl2.start_enable_bit && st_r.stat.port_interrupt_flag
		##1 !st_r.sda_oe_n && !st_r.scl_oe_n)
		else $error("start end sequence wrong");
	chk_start_abort: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.m_state == M_START_WAIT && !st_r.scl_s && st_r.ctrl1.port_enable_bit
		|=> st_r.stat.bus_collision_flag && st_r.m_state == M_IDLE)
		else $error("start collision not aborted");
	chk_baud_pause: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.m_state == M_BIT_HIGH && !st_r.scl_s && st_r.ctrl1.port_enable_bit
		|=> st_r.baud_counter == $past(st_r.addr_baud))
		else $error("baud counter ran while scl low");
	chk_off_clear: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		!st_r.ctrl1.port_enable_bit |=> !st_r.stat.start_seen && !st_r.stat.stop_seen)
		else $error("seen flags kept while disabled");
	cov_start: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.m_state == M_START_HOLD ##1 st_r.m_state == M_IDLE);
	cov_byte: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		st_r.m_state == M_BIT_HIGH && st_r.m_bit == BITS_PER_BYTE ##1 st_r.m_state == M_IDLE);
	cov_slave_hit: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		$rose(st_r.s_ack));

endmodule : isc_top

/* File: testbench/isc_peer.sv */
// far-side peer model: a bus master driving the two open-drain wires
`timescale 1ns/1ps
module isc_peer (
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	output logic scl,
	output logic sda
);
	logic pull_scl = 1'b0;
	logic pull_sda = 1'b0;
	// count of clock releases that never came back high
	int stuck = 0;
	// ==========================================================
	// wired-and with pull-up: any party pulling wins
	assign scl = scl_oe_n & ~pull_scl;
	assign sda = sda_oe_n & ~pull_sda;
	// ==========================================================
	// release scl and wait, bounded, while a slave stretches it
	task rise_scl();
		int k;
		pull_scl = 1'b0;
		// look at the block's enable, not the wire: the wire settles later in this step
		for (k = 0; k < 400 && !scl_oe_n; k++) #10;
		if (!scl_oe_n) begin
			stuck++;
		end
	endtask : rise_scl
	// sda falls while scl is high
	task start_cond();
		pull_sda = 1'b1;
		#62.5 pull_scl = 1'b1;
	endtask : start_cond
	// sda rises while scl is high
	task stop_cond();
		pull_sda = 1'b1;
		#62.5;
		rise_scl();
		#62.5 pull_sda = 1'b0;
		#62.5;
	endtask : stop_cond
	// msb first; the ninth clock samples the answer mid-high
	task send_byte(input logic [7:0] b, output logic nack);
		int i;
		for (i = 7; i >= 0; i--) begin
			#31 pull_sda = ~b[i];
			#31.5;
			rise_scl();
			#62.5 pull_scl = 1'b1;
		end
		#31 pull_sda = 1'b0;
		#31.5;
		rise_scl();
		#31 nack = sda;
		#31.5 pull_scl = 1'b1;
	endtask : send_byte
endmodule : isc_peer

/* File: testbench/isc_top_test.sv */
// self-checking bench of the i2c port block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module isc_top_test;
	import isc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic scl, sda, scl_out, sda_out, scl_oe_n, sda_oe_n;
	int bad_count = 0;
	int samples_checked = 0;
	logic [7:0] v;
	logic nk;
	// ==========================================================
	// clock, design and far-side peer
	always #5 clk = ~clk;
	isc_top isc_top_inst (.REF_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(scl_out),
		.SCL_OE_N(scl_oe_n), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n));
	isc_peer isc_peer_inst (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
	task final_report();
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// ==========================================================
	// register port: one idle cycle between strobes avoids double drives
	task wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	// bounded wait for an output enable to go low
	task wait_oe(input logic sel_scl);
		int i;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk);
			#1;
			if ((sel_scl ? scl_oe_n : sda_oe_n) === 1'b0) break;
		end
		if (i == 2000) begin
			bad_count++;
			final_report();
		end
	endtask : wait_oe
	task do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(REG_MASK, v);
		`CHK(v, MASK_RST)
		rd_reg(REG_STATUS, v);
		`CHK(v, 8'h00)
	endtask : do_reset
	// ==========================================================
	// start with a refused buffer write and locked control bits
	task master_start();
		int i;
		do_reset();
		wr_reg(REG_ADDR_BAUD, 8'h06);
		wr_reg(REG_CTRL1, 8'h28);
		`CHK(sda_oe_n, 1'b1)
		wr_reg(REG_CTRL2, 8'h01);
		wr_reg(REG_BUF, 8'ha5);
		wr_reg(REG_CTRL2, 8'h05);
		wait_oe(1'b0);
		`CHK(scl_oe_n, 1'b1)
		wait_oe(1'b1);
		repeat (3) @(posedge clk);
		rd_reg(REG_CTRL2, v);
		`CHK(v[4:0], 5'h00)
		rd_reg(REG_STATUS, v);
		`CHK(v[7], 1'b1)
		`CHK(v[0], 1'b1)
		rd_reg(REG_BUF, v);
		`CHK(v, 8'h00)
		`CHK(sda_oe_n, 1'b0)
		// address byte with nobody answering: ninth bit reads high
		wr_reg(REG_STATUS, 8'h81);
		wr_reg(REG_BUF, 8'h5a);
		for (i = 0; i < 150 && v[0] !== 1'b1; i++) begin
			rd_reg(REG_STATUS, v);
		end
		`CHK(v[0], 1'b1)
		if (v[0] !== 1'b1) begin
			final_report();
		end
		`CHK(v[5], 1'b0)
		rd_reg(REG_CTRL2, v);
		`CHK(v[6], 1'b1)
	endtask : master_start
	// both wires already low when the start is asked for
	task start_collision();
		do_reset();
		isc_peer_inst.pull_scl = 1'b1;
		isc_peer_inst.pull_sda = 1'b1;
		wr_reg(REG_CTRL1, 8'h28);
		wr_reg(REG_CTRL2, 8'h01);
		repeat (20) @(posedge clk);
		rd_reg(REG_STATUS, v);
		`CHK(v[1], 1'b1)
		`CHK(sda_oe_n, 1'b1)
		isc_peer_inst.pull_scl = 1'b0;
		isc_peer_inst.pull_sda = 1'b0;
	endtask : start_collision
	// general call, then an exact miss, then a masked hit
	task slave_gc_mask();
		do_reset();
		wr_reg(REG_ADDR_BAUD, 8'h50);
		wr_reg(REG_CTRL2, 8'h80);
		wr_reg(REG_CTRL1, 8'h36);
		isc_peer_inst.start_cond();
		isc_peer_inst.send_byte(8'h00, nk);
		`CHK(nk, 1'b0)
		rd_reg(REG_STATUS, v);
		`CHK(v[0], 1'b1)
		isc_peer_inst.stop_cond();
		// address hold: general call stretched until software releases
		wr_reg(REG_CTRL3, 8'h01);
		isc_peer_inst.start_cond();
		fork
			isc_peer_inst.send_byte(8'h00, nk);
			begin
				repeat (150) @(posedge clk);
				`CHK(scl_oe_n, 1'b0)
				rd_reg(REG_CTRL1, v);
				`CHK(v[4], 1'b0)
				wr_reg(REG_CTRL1, 8'h36);
			end
		join
		`CHK(nk, 1'b0)
		isc_peer_inst.stop_cond();
		wr_reg(REG_CTRL3, 8'h00);
		isc_peer_inst.start_cond();
		isc_peer_inst.send_byte(8'h52, nk);
		`CHK(nk, 1'b1)
		isc_peer_inst.stop_cond();
		wr_reg(REG_MASK, 8'hf0);
		isc_peer_inst.start_cond();
		isc_peer_inst.send_byte(8'h52, nk);
		`CHK(nk, 1'b0)
		isc_peer_inst.stop_cond();
		`CHK(isc_peer_inst.stuck, 0)
	endtask : slave_gc_mask
	initial begin
		master_start();
		start_collision();
		slave_gc_mask();
		final_report();
	end
endmodule : isc_top_test
